// *** rtl/oci_pkg.sv ***
/*
  Constants shared by the output compare idle and interrupt block: register
  indices and byte addresses, control field positions, mode codes, reset
  values, interrupt bit positions and bus response codes.
  Assumes a 32-bit AXI4-Lite bus with one aligned word per register.
*/
package oci_pkg;

  // Register indices as printed; the byte address is four times the index.
  localparam int unsigned ADDR_W = 14;
  localparam logic [11:0] IDX_SECONDARY = 12'h180;
  localparam logic [11:0] IDX_MAIN = 12'h182;
  localparam logic [11:0] IDX_CONTROL = 12'h184;
  localparam logic [11:0] IDX_IRQ_STATUS = 12'h190;
  localparam logic [11:0] IDX_IRQ_ENABLE = 12'h191;
  localparam logic [13:0] ADDR_SECONDARY = {IDX_SECONDARY, 2'b00};
  localparam logic [13:0] ADDR_MAIN = {IDX_MAIN, 2'b00};
  localparam logic [13:0] ADDR_CONTROL = {IDX_CONTROL, 2'b00};
  localparam logic [13:0] ADDR_IRQ_STATUS = {IDX_IRQ_STATUS, 2'b00};
  localparam logic [13:0] ADDR_IRQ_ENABLE = {IDX_IRQ_ENABLE, 2'b00};

  // Control register layout.
  localparam int unsigned CTL_SIDL_BIT = 13;
  localparam int unsigned CTL_TSEL_BIT = 3;
  localparam int unsigned MODE_W = 3;
  localparam logic [15:0] CONTROL_WMASK = 16'h200f;

  // Mode codes; the two highest codes select PWM.
  localparam logic [2:0] MODE_OFF = 3'h0;
  localparam logic [1:0] MODE_PWM_TOP = 2'h3;

  // Reset values.
  localparam logic [15:0] SECONDARY_RST = 16'h0000;
  localparam logic [15:0] MAIN_RST = 16'h0000;
  localparam logic [15:0] CONTROL_RST = 16'h0000;

  // Interrupt status and enable bit positions.
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_CMP = 0;
  localparam int unsigned IRQ_TA = 1;
  localparam int unsigned IRQ_TB = 2;
  localparam logic [2:0] IRQ_ENABLE_RST = 3'h0;

  // AXI response codes.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

// *** rtl/oci_flag.sv ***
/*
  One sticky interrupt flag: hardware sets it, software clears it.
  Assumes set and clear are single-cycle pulses on the same clock.
*/
`timescale 1ns/1ps
module oci_flag (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic set,
  input wire logic clr,
  output logic flag_q
);

  // Set wins over clear so an event in the clearing cycle is not lost.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_q <= 1'b0;
    end else if (set) begin
      flag_q <= 1'b1;
    end else if (clr) begin
      flag_q <= 1'b0;
    end
  end

endmodule // oci_flag

// *** rtl/oci_axil.sv ***
/*
  AXI4-Lite slave front end: takes write address and data in either order,
  issues one write strobe, and answers reads one edge after the address.
  Assumes the parent decodes addresses combinationally and reports a hit.
*/
`timescale 1ns/1ps
module oci_axil (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [13:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic wr_en,
  output logic [13:0] wr_addr,
  output logic [31:0] wr_data,
  output logic [3:0] wr_strb,
  input wire logic wr_ok,
  output logic rd_en,
  output logic [13:0] rd_addr,
  input wire logic [31:0] rd_data,
  input wire logic rd_ok
);

  logic aw_held_q;
  logic w_held_q;

  // The write happens once both halves are held and no response is pending.
  assign wr_en = aw_held_q && w_held_q && !bvalid;
  assign rd_en = arvalid && arready;
  assign rd_addr = araddr;

  // Capture the write address and hold it until the write is done.
  // Ready is its own flop so the port comes straight from a register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      awready <= 1'b1;
      wr_addr <= '0;
    end else if (awvalid && !aw_held_q) begin
      aw_held_q <= 1'b1;
      awready <= 1'b0;
      wr_addr <= awaddr;
    end else if (wr_en) begin
      aw_held_q <= 1'b0;
      awready <= 1'b1;
    end
  end

  // Capture the write data and strobes independently of the address.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wready <= 1'b1;
      wr_data <= '0;
      wr_strb <= '0;
    end else if (wvalid && !w_held_q) begin
      w_held_q <= 1'b1;
      wready <= 1'b0;
      wr_data <= wdata;
      wr_strb <= wstrb;
    end else if (wr_en) begin
      w_held_q <= 1'b0;
      wready <= 1'b1;
    end
  end

  // Write response; an unmapped address answers with a slave error.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= oci_pkg::RESP_OKAY;
    end else if (wr_en) begin
      bvalid <= 1'b1;
      bresp <= wr_ok ? oci_pkg::RESP_OKAY : oci_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid <= 1'b0;
    end
  end

  // Read channel: one read at a time, data sampled at the address edge.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= '0;
      rresp <= oci_pkg::RESP_OKAY;
    end else if (rd_en) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_ok ? rd_data : 32'h0000_0000;
      rresp <= rd_ok ? oci_pkg::RESP_OKAY : oci_pkg::RESP_SLVERR;
    end else if (rvalid && rready) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
    end
  end

endmodule // oci_axil

// *** rtl/oci_top.sv ***
/*
  Output compare channel: idle gating, interrupt flags and requests, and the
  compare, secondary compare and control registers behind AXI4-Lite.
  Assumes timers, match logic and core idle come from logic on aclk.
*/
// What this block does
// - Channel runs all modes during idle when allowed.
// - Idle run needs stop bit clear, timer on, timer idle stop clear.
// - Non-PWM compare events set channel flag.
// - Channel flag stays set until software clears.
// - Channel request only when flag and enable.
// - PWM events set selected timer's flag.
// - Timer request only when flag and enable.
// - Timer flag stays set until software clears.
// - PWM mode never sets channel flag.
// - Secondary compare at 0180, resets to zero.
// - Mode codes 110 and 111 mean PWM.
// - Timer select bit picks timer, default first.
// - PWM event follows count reaching period.
`timescale 1ns/1ps
module oci_top (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [13:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [13:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic core_idle,
  input wire logic compare_event,
  input wire logic timer_a_on,
  input wire logic timer_a_stop_in_idle,
  input wire logic timer_a_tick,
  input wire logic [15:0] timer_a_count,
  input wire logic [15:0] timer_a_period,
  input wire logic timer_b_on,
  input wire logic timer_b_stop_in_idle,
  input wire logic timer_b_tick,
  input wire logic [15:0] timer_b_count,
  input wire logic [15:0] timer_b_period,
  output logic irq,
  output logic compare_irq_req,
  output logic timer_a_irq_req,
  output logic timer_b_irq_req,
  output logic channel_run,
  output logic [2:0] compare_mode_select,
  output logic timer_select,
  output logic [15:0] secondary_compare,
  output logic [15:0] main_compare
);

  logic wr_en;
  logic [13:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [13:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  logic [15:0] wr_word;
  logic [15:0] wr_mask;
  logic channel_stop_in_idle;
  logic pwm_mode;
  logic active;
  logic sel_on;
  logic sel_sidl;
  logic sel_tick;
  logic period_hit;
  logic pwm_event;
  logic cmp_set;
  logic [2:0] irq_set;
  logic [2:0] irq_clr;
  logic [2:0] irq_status;
  logic [2:0] irq_enable_q;
  logic [15:0] control;

  oci_axil u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(awaddr),
    .awvalid(awvalid),
    .awready(awready),
    .wdata(wdata),
    .wstrb(wstrb),
    .wvalid(wvalid),
    .wready(wready),
    .bresp(bresp),
    .bvalid(bvalid),
    .bready(bready),
    .araddr(araddr),
    .arvalid(arvalid),
    .arready(arready),
    .rdata(rdata),
    .rresp(rresp),
    .rvalid(rvalid),
    .rready(rready),
    .wr_en(wr_en),
    .wr_addr(wr_addr),
    .wr_data(wr_data),
    .wr_strb(wr_strb),
    .wr_ok(wr_ok),
    .rd_en(),
    .rd_addr(rd_addr),
    .rd_data(rd_data),
    .rd_ok(rd_ok)
  );

  // Byte lanes 0 and 1 carry the 16-bit registers; upper lanes are ignored.
  assign wr_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};
  assign wr_word = wr_data[15:0];

  // Mode decode and timer selection.
  assign pwm_mode = compare_mode_select[2:1] == oci_pkg::MODE_PWM_TOP;
  assign sel_on = timer_select ? timer_b_on : timer_a_on;
  assign sel_sidl = timer_select ? timer_b_stop_in_idle : timer_a_stop_in_idle;
  assign sel_tick = timer_select ? timer_b_tick : timer_a_tick;
  assign period_hit = timer_select ? (timer_b_count == timer_b_period)
                                   : (timer_a_count == timer_a_period);

  // Outside idle the channel always runs; in idle all three conditions
  // must hold, otherwise compare and period events are ignored and channel_run drops.
  assign active = !core_idle || (!channel_stop_in_idle && sel_on && !sel_sidl);

  // The period event is a tick in the same cycle that count equals period.
  assign pwm_event = active && pwm_mode && sel_tick && period_hit;
  assign cmp_set = active && !pwm_mode && compare_event;

  // Flag set sources: channel flag outside PWM, timer flags in PWM.
  always_comb begin
    irq_set = 3'h0;
    irq_set[oci_pkg::IRQ_CMP] = cmp_set;
    irq_set[oci_pkg::IRQ_TA] = pwm_event && !timer_select;
    irq_set[oci_pkg::IRQ_TB] = pwm_event && timer_select;
  end

  // Only a software write of one clears a flag; hardware never does.
  assign irq_clr = (wr_en && wr_addr == oci_pkg::ADDR_IRQ_STATUS && wr_strb[0])
                   ? wr_data[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < oci_pkg::IRQ_W; gi++) begin : g_flag
      oci_flag u_flag (
        .aclk(aclk),
        .aresetn(aresetn),
        .set(irq_set[gi]),
        .clr(irq_clr[gi]),
        .flag_q(irq_status[gi])
      );
    end
  endgenerate

  // Control register; the fault bit is not kept here and reads zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      channel_stop_in_idle <= oci_pkg::CONTROL_RST[oci_pkg::CTL_SIDL_BIT];
      timer_select <= oci_pkg::CONTROL_RST[oci_pkg::CTL_TSEL_BIT];
      compare_mode_select <= oci_pkg::CONTROL_RST[2:0];
    end else if (wr_en && wr_addr == oci_pkg::ADDR_CONTROL) begin
      if (wr_strb[1]) begin
        channel_stop_in_idle <= wr_word[oci_pkg::CTL_SIDL_BIT];
      end
      if (wr_strb[0]) begin
        timer_select <= wr_word[oci_pkg::CTL_TSEL_BIT];
        compare_mode_select <= wr_word[2:0];
      end
    end
  end

  // Secondary compare, a plain read-write word that clears on reset.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      secondary_compare <= oci_pkg::SECONDARY_RST;
    end else if (wr_en && wr_addr == oci_pkg::ADDR_SECONDARY) begin
      secondary_compare <= (secondary_compare & ~wr_mask) | (wr_word & wr_mask);
    end
  end

  // Main compare: writable outside PWM; in PWM it is a read-only latch
  // loaded from the secondary at each period, which keeps duty glitchless.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      main_compare <= oci_pkg::MAIN_RST;
    end else if (pwm_event) begin
      main_compare <= secondary_compare;
    end else if (wr_en && wr_addr == oci_pkg::ADDR_MAIN && !pwm_mode) begin
      main_compare <= (main_compare & ~wr_mask) | (wr_word & wr_mask);
    end
  end

  // Interrupt enable register, same layout as the status register.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_enable_q <= oci_pkg::IRQ_ENABLE_RST;
    end else if (wr_en && wr_addr == oci_pkg::ADDR_IRQ_ENABLE && wr_strb[0]) begin
      irq_enable_q <= wr_data[2:0];
    end
  end

  // Registered requests; each needs its flag and its own enable.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      compare_irq_req <= 1'b0;
      timer_a_irq_req <= 1'b0;
      timer_b_irq_req <= 1'b0;
      irq <= 1'b0;
      channel_run <= 1'b0;
    end else begin
      compare_irq_req <= irq_status[0] && irq_enable_q[0];
      timer_a_irq_req <= irq_status[1] && irq_enable_q[1];
      timer_b_irq_req <= irq_status[2] && irq_enable_q[2];
      irq <= |(irq_status & irq_enable_q);
      channel_run <= active;
    end
  end

  // Read decode and address check; registers above bit 15 read zero.
  assign control = {2'b00, channel_stop_in_idle, 9'h000, timer_select,
                    compare_mode_select};
  always_comb begin
    rd_ok = 1'b1;
    unique case (rd_addr)
      oci_pkg::ADDR_SECONDARY: rd_data = {16'h0000, secondary_compare};
      oci_pkg::ADDR_MAIN: rd_data = {16'h0000, main_compare};
      oci_pkg::ADDR_CONTROL: rd_data = {16'h0000, control};
      oci_pkg::ADDR_IRQ_STATUS: rd_data = {29'h0, irq_status};
      oci_pkg::ADDR_IRQ_ENABLE: rd_data = {29'h0, irq_enable_q};
      default: begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b0;
      end
    endcase
  end
  assign wr_ok = (wr_addr == oci_pkg::ADDR_SECONDARY) ||
                 (wr_addr == oci_pkg::ADDR_MAIN) ||
                 (wr_addr == oci_pkg::ADDR_CONTROL) ||
                 (wr_addr == oci_pkg::ADDR_IRQ_STATUS) ||
                 (wr_addr == oci_pkg::ADDR_IRQ_ENABLE);

  // Checks on the behaviour above.
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  idle_stop_a: assert property (
    core_idle && channel_stop_in_idle |=> !channel_run)
    else $error("channel ran in idle with stop bit set");
  idle_run_a: assert property (
    core_idle && !channel_stop_in_idle && sel_on && !sel_sidl |=> channel_run)
    else $error("channel stopped although idle run allowed");
  cmp_flag_set_a: assert property (
    compare_event && channel_run && !core_idle && !pwm_mode
    |=> irq_status[0])
    else $error("compare event did not set channel flag");
  cmp_flag_hold_a: assert property (
    irq_status[0] && !irq_clr[0] |=> irq_status[0])
    else $error("channel flag cleared without software");
  cmp_req_a: assert property (
    compare_irq_req == ($past(irq_status[0]) && $past(irq_enable_q[0])))
    else $error("channel request does not follow flag and enable");
  irq_sum_a: assert property (
    irq == |($past(irq_status) & $past(irq_enable_q)))
    else $error("summary request does not follow flags and enables");
  pwm_timer_flag_a: assert property (
    pwm_event |=> (timer_select ? irq_status[2] : irq_status[1])
                  || $past(timer_select) != timer_select)
    else $error("period event did not set selected timer flag");
  timer_req_a: assert property (
    !irq_status[1] || !irq_enable_q[1] |=> !timer_a_irq_req)
    else $error("timer request without flag and enable");
  timer_flag_hold_a: assert property (
    irq_status[2] && !irq_clr[2] |=> irq_status[2])
    else $error("timer flag cleared without software");
  pwm_no_cmp_a: assert property (
    $rose(irq_status[0]) |-> !$past(pwm_mode))
    else $error("channel flag set during pwm");
  sec_reset_a: assert property (
    $rose(aresetn) |-> secondary_compare == 16'h0000)
    else $error("secondary compare not zero after reset");
  duty_latch_a: assert property (
    pwm_event |=> main_compare == $past(secondary_compare))
    else $error("duty not latched at period event");
  frozen_a: assert property (
    !active |=> !$rose(irq_status[0]) && !$rose(irq_status[1]) &&
                !$rose(irq_status[2]))
    else $error("flag set while suspended");

  cmp_irq_c: cover property (cmp_set ##[1:4] compare_irq_req);
  idle_run_c: cover property (core_idle && active && cmp_set);
  pwm_tb_c: cover property (pwm_event && timer_select);
  idle_block_c: cover property (core_idle && !active);
  set_clr_c: cover property (irq_set[0] && irq_clr[0]);

endmodule // oci_top

// *** sim/oci_timer_model.sv ***
/*
  Far-side model of one shared timer: it ticks every cycle while on and
  clears on the increment after its count matches its period.
  Assumes the same clock and reset as the block under test.
*/
`timescale 1ns/1ps
module oci_timer_model #(
  parameter logic [15:0] PERIOD = 16'h0007
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic on,
  output logic tick,
  output logic [15:0] count,
  output logic [15:0] period
);
  logic [15:0] count_q;

  // A stopped timer neither ticks nor counts, so no event can be faked.
  assign tick = on;
  assign period = PERIOD;
  assign count = count_q;

  // Wrap to zero on the increment that follows a period match.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count_q <= 16'h0000;
    end else if (on) begin
      count_q <= (count_q == PERIOD) ? 16'h0000 : count_q + 16'h0001;
    end
  end
endmodule // oci_timer_model

// *** sim/output_compare_idle_and_interrupts_tb_top.sv ***
/*
  Bench for oci_top: bus tasks, an integer model of flags and enables,
  and an exhaustive sweep of the idle gating conditions.
  Assumes oci_pkg, oci_top and the timer model are compiled first.
*/
`timescale 1ns/1ps
module output_compare_idle_and_interrupts_tb_top;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic core_idle, compare_event, timer_a_on, timer_b_on;
  logic timer_a_stop_in_idle, timer_b_stop_in_idle, timer_a_tick;
  logic timer_b_tick, irq, compare_irq_req, timer_a_irq_req;
  logic timer_b_irq_req, channel_run, timer_select;
  logic [15:0] timer_a_count, timer_a_period, timer_b_count;
  logic [15:0] timer_b_period, secondary_compare, main_compare;
  logic [2:0] compare_mode_select;
  logic [1:0] r;
  int err_count, comparisons, exp_st, exp_en;

  oci_top dut (
    .aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid,
    .arready, .rdata, .rresp, .rvalid, .rready, .core_idle,
    .compare_event, .timer_a_on, .timer_a_stop_in_idle, .timer_a_tick,
    .timer_a_count, .timer_a_period, .timer_b_on, .timer_b_stop_in_idle,
    .timer_b_tick, .timer_b_count, .timer_b_period, .irq,
    .compare_irq_req, .timer_a_irq_req, .timer_b_irq_req, .channel_run,
    .compare_mode_select, .timer_select, .secondary_compare,
    .main_compare
  );

  // Two timers with unequal periods so a wrong selection shows.
  oci_timer_model #(.PERIOD(16'h0007)) tmr_a (.aclk, .aresetn,
    .on(timer_a_on), .tick(timer_a_tick), .count(timer_a_count),
    .period(timer_a_period));
  oci_timer_model #(.PERIOD(16'h0005)) tmr_b (.aclk, .aresetn,
    .on(timer_b_on), .tick(timer_b_tick), .count(timer_b_count),
    .period(timer_b_period));

  // Free-running bench clock at 200 MHz.
  initial aclk = 1'b0;
  always #2.5 aclk = ~aclk;

  // Prints the counts and the verdict, then stops the run.
  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", comparisons, err_count);
    if (err_count == 0 && comparisons > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Write: address and data offered together, each dropped once taken.
  task automatic axw(input logic [13:0] a, input logic [31:0] d);
    bit aw, w;
    aw = 0;
    w = 0;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'h3;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      aw = aw | awready;
      w = w | wready;
      awvalid <= !aw;
      wvalid <= !w;
    end
    do @(posedge aclk); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask

  task automatic axr(input logic [13:0] a, output logic [31:0] d);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge aclk); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // Reads a mapped register and expects its value with an OKAY answer.
  task automatic rc(input string nm, input logic [13:0] a,
                    input logic [31:0] e);
    logic [31:0] d;
    axr(a, d);
    chk(nm, d, e);
    chk({nm, " resp"}, {30'h0, r}, {30'h0, oci_pkg::RESP_OKAY});
  endtask

  // Compares requests, the summary line and status with the model.
  task automatic chk_irq(input string nm);
    repeat (3) @(posedge aclk);
    chk({nm, " req"},
        {29'h0, timer_b_irq_req, timer_a_irq_req, compare_irq_req},
        exp_st & exp_en);
    chk({nm, " irq"}, {31'h0, irq},
        {31'h0, (exp_st & exp_en) != 0});
    rc({nm, " status"}, oci_pkg::ADDR_IRQ_STATUS, exp_st);
  endtask

  task automatic setctl(input int stop, input int ts, input int m);
    axw(oci_pkg::ADDR_CONTROL, (stop << oci_pkg::CTL_SIDL_BIT) |
        (ts << oci_pkg::CTL_TSEL_BIT) | m);
  endtask

  task automatic pulse();
    @(posedge aclk);
    compare_event <= 1'b1;
    @(posedge aclk);
    compare_event <= 1'b0;
    repeat (2) @(posedge aclk);
  endtask

  task automatic enable(input int e);
    axw(oci_pkg::ADDR_IRQ_ENABLE, e);
    exp_en = e;
  endtask

  // Software clears every flag with a write of ones.
  task automatic clr();
    axw(oci_pkg::ADDR_IRQ_STATUS, 32'h7);
    exp_st = 0;
  endtask

  // Cuts a hang short; the tests need a few thousand cycles.
  initial begin
    repeat (40000) @(posedge aclk);
    err_count++;
    tally_and_finish();
  end

  initial begin
    logic [31:0] v;
    int act;
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {core_idle, compare_event, timer_a_on, timer_b_on} = '0;
    {timer_a_stop_in_idle, timer_b_stop_in_idle} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    exp_st = 0;
    exp_en = 0;
    void'($urandom(32'hc6c7));
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rc("secondary", oci_pkg::ADDR_SECONDARY, 32'h0);
    rc("control", oci_pkg::ADDR_CONTROL, 32'h0);
    rc("enable", oci_pkg::ADDR_IRQ_ENABLE, 32'h0);
    axr(14'h3ffc, v);
    chk("unmapped rresp", {30'h0, r},
        {30'h0, oci_pkg::RESP_SLVERR});
    axw(14'h3ffc, 32'h1);
    chk("unmapped bresp", {30'h0, r},
        {30'h0, oci_pkg::RESP_SLVERR});
    v = $urandom;
    axw(oci_pkg::ADDR_SECONDARY, {16'h0, v[15:0]});
    rc("secondary rw", oci_pkg::ADDR_SECONDARY, {16'h0, v[15:0]});
    chk("secondary out", {16'h0, secondary_compare},
        {16'h0, v[15:0]});
    setctl(1, 1, 5);
    rc("control rw", oci_pkg::ADDR_CONTROL, 32'h0000_200d);
    $display("test registers done");
    // Every non-PWM mode code sets the channel flag until cleared.
    for (int m = 0; m < 6; m++) begin
      setctl(0, m % 2, m);
      pulse();
      exp_st = 1;
      chk_irq("cmp set");
      repeat (10) @(posedge aclk);
      chk_irq("cmp held");
      enable(1);
      chk_irq("cmp enabled");
      clr();
      chk_irq("cmp cleared");
      enable(0);
    end
    $display("test compare flag done");
    // PWM codes on each timer: timer flag only, duty latched.
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      axw(oci_pkg::ADDR_SECONDARY, {16'h0, v[15:0]});
      setctl(0, i % 2, 6 + i / 2);
      pulse();
      chk_irq("pwm no cmp");
      timer_a_on <= 1'b1;
      timer_b_on <= 1'b1;
      repeat (20) @(posedge aclk);
      timer_a_on <= 1'b0;
      timer_b_on <= 1'b0;
      exp_st = (i % 2) ? 4 : 2;
      chk_irq("pwm flag");
      chk("main", {16'h0, main_compare}, {16'h0, v[15:0]});
      enable(7);
      chk_irq("pwm enabled");
      repeat (10) @(posedge aclk);
      chk_irq("pwm held");
      clr();
      enable(0);
    end
    $display("test pwm flag done");
    // All combinations of stop bit, selection and timer state in idle.
    core_idle <= 1'b1;
    for (int c = 0; c < 64; c++) begin
      setctl(c[0], c[1], 1);
      chk("tsel", {31'h0, timer_select}, {31'h0, c[1]});
      chk("mode", {29'h0, compare_mode_select}, 32'h1);
      {timer_a_on, timer_a_stop_in_idle} <= c[3:2];
      {timer_b_on, timer_b_stop_in_idle} <= c[5:4];
      // Bit 3 or 5 is the timer's on bit, bit 2 or 4 its stop bit.
      act = !c[0] && (c[1] ? (c[5] && !c[4]) : (c[3] && !c[2]));
      pulse();
      chk("run", {31'h0, channel_run}, act);
      exp_st = act;
      chk_irq("idle");
      clr();
    end
    $display("test idle done");
    tally_and_finish();
  end
endmodule // output_compare_idle_and_interrupts_tb_top
